// >>> hdl/rh_desc_pkg.sv
// What this block does
// - Power-good delay byte, units of 2 ms.
// - Bit 12 set means no overcurrent reporting.
// - Bit 11 selects collective or per-port overcurrent.
// - Overcurrent mode resets equal to switch mode.
// - Compound device bit always reads zero.
// - Bit 8 selects ganged or individual switching.
// - With bit 8 set and bit 9 clear, masked ports obey only per-port power commands.
// - Downstream port count, at most two.
// - Read command 12h, write command 92h.
// - Writes accepted in any USB state.
package rh_desc_pkg;
   localparam logic [7:0] CMD_READ = 8'h12;
   localparam logic [7:0] CMD_WRITE = 8'h92;
   localparam int POWER_GOOD_LSB = 24;
   localparam int NO_OC_BIT = 12;
   localparam int OC_MODE_BIT = 11;
   localparam int COMPOUND_BIT = 10;
   localparam int NO_PSW_BIT = 9;
   localparam int PSW_MODE_BIT = 8;
   localparam int PORT_COUNT_LSB = 0;
   localparam int POWER_GOOD_UNIT_MS = 2;
   localparam logic [7:0] RESET_POWER_GOOD = 8'h01;
   localparam logic RESET_NO_OC = 1'b0;
   localparam logic RESET_NO_PSW = 1'b0;
   localparam logic RESET_PSW_MODE = 1'b1;
   localparam logic [1:0] MAX_PORTS = 2'h2;
   localparam int NUM_PORTS = 2;
endpackage

// >>> hdl/root_hub_descriptor_a.sv
`timescale 1ns/1ps
`default_nettype none
module root_hub_descriptor_a (
   input wire logic CLK_SYS, // System clock, 125 MHz.
   input wire logic RST, // Asynchronous reset, active high.
   input wire logic CMD_VALID, // One-cycle command strobe.
   input wire logic [7:0] CMD_CODE, // Command code.
   input wire logic [31:0] WR_DATA, // Write data with the command.
   input wire logic [1:0] PORT_COUNT_STRAP, // Fitted downstream ports.
   input wire logic GLOBAL_POWER_ON, // Pulse, global power on.
   input wire logic GLOBAL_POWER_OFF, // Pulse, global power off.
   input wire logic [2:0] PORT_POWER_MASK, // Per-port mask, bit 0 unused.
   input wire logic [2:0] PORT_POWER_SET, // Pulse per port, power on.
   input wire logic [2:0] PORT_POWER_CLR, // Pulse per port, power off.
   output logic [31:0] RD_DATA, // Register read value.
   output logic RD_VALID, // One-cycle read answer strobe.
   output logic [7:0] POWER_GOOD_DELAY, // Delay field in 2 ms units.
   output logic OC_REPORT_PER_PORT, // Per-port overcurrent reporting active.
   output logic OC_REPORT_NONE, // No overcurrent reporting.
   output logic [2:0] PORT_POWER // Port power state, bit 0 unused.
);
   logic [7:0] power_good_delay;
   logic no_overcurrent_support;
   logic overcurrent_report_mode;
   logic no_power_switching;
   logic power_switch_mode;
   logic [1:0] downstream_port_count;
   logic [2:0] port_power;
   logic [2:0] next_port_power;
   logic [31:0] reg_value;
   logic [1:0] strap_limited;
   wire is_write = CMD_VALID && (CMD_CODE == rh_desc_pkg::CMD_WRITE);
   wire is_read = CMD_VALID && (CMD_CODE == rh_desc_pkg::CMD_READ);
   assign strap_limited = (PORT_COUNT_STRAP > rh_desc_pkg::MAX_PORTS) ?
      rh_desc_pkg::MAX_PORTS : PORT_COUNT_STRAP;
   always_comb begin
      reg_value = 32'h0;
      reg_value[rh_desc_pkg::POWER_GOOD_LSB +: 8] = power_good_delay;
      reg_value[rh_desc_pkg::NO_OC_BIT] = no_overcurrent_support;
      reg_value[rh_desc_pkg::OC_MODE_BIT] = overcurrent_report_mode;
      reg_value[rh_desc_pkg::COMPOUND_BIT] = 1'b0;
      reg_value[rh_desc_pkg::NO_PSW_BIT] = no_power_switching;
      reg_value[rh_desc_pkg::PSW_MODE_BIT] = power_switch_mode;
      reg_value[rh_desc_pkg::PORT_COUNT_LSB +: 2] = downstream_port_count;
   end
   always_comb begin
      next_port_power = port_power;
      for (int i = 1; i <= rh_desc_pkg::NUM_PORTS; i++) begin
         if (no_power_switching) begin
            next_port_power[i] = 1'b1;
         end else if (power_switch_mode && PORT_POWER_MASK[i]) begin
            if (PORT_POWER_SET[i]) begin
               next_port_power[i] = 1'b1;
            end else if (PORT_POWER_CLR[i]) begin
               next_port_power[i] = 1'b0;
            end
         end else begin
            if (GLOBAL_POWER_ON) begin
               next_port_power[i] = 1'b1;
            end else if (GLOBAL_POWER_OFF) begin
               next_port_power[i] = 1'b0;
            end
         end
      end
      next_port_power[0] = 1'b0;
   end
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         power_good_delay <= rh_desc_pkg::RESET_POWER_GOOD;
         no_overcurrent_support <= rh_desc_pkg::RESET_NO_OC;
         overcurrent_report_mode <= rh_desc_pkg::RESET_PSW_MODE;
         no_power_switching <= rh_desc_pkg::RESET_NO_PSW;
         power_switch_mode <= rh_desc_pkg::RESET_PSW_MODE;
      end else if (is_write) begin
         power_good_delay <= WR_DATA[rh_desc_pkg::POWER_GOOD_LSB +: 8];
         no_overcurrent_support <= WR_DATA[rh_desc_pkg::NO_OC_BIT];
         overcurrent_report_mode <= WR_DATA[rh_desc_pkg::OC_MODE_BIT];
         no_power_switching <= WR_DATA[rh_desc_pkg::NO_PSW_BIT];
         power_switch_mode <= WR_DATA[rh_desc_pkg::PSW_MODE_BIT];
      end
   end
   // The port count is read-only; it follows the board strap, clipped to two.
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         downstream_port_count <= 2'h0;
      end else begin
         downstream_port_count <= strap_limited;
      end
   end
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         port_power <= 3'h0;
         RD_DATA <= 32'h0;
         RD_VALID <= 1'b0;
         POWER_GOOD_DELAY <= 8'h0;
         OC_REPORT_PER_PORT <= 1'b0;
         OC_REPORT_NONE <= 1'b0;
         PORT_POWER <= 3'h0;
      end else begin
         port_power <= next_port_power;
         RD_VALID <= is_read;
         if (is_read) begin
            RD_DATA <= reg_value;
         end
         POWER_GOOD_DELAY <= power_good_delay;
         OC_REPORT_PER_PORT <= !no_overcurrent_support && overcurrent_report_mode;
         OC_REPORT_NONE <= no_overcurrent_support;
         PORT_POWER <= next_port_power;
      end
   end
endmodule
`default_nettype wire

// >>> test/rh_desc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rh_desc_assertions (
   input wire logic CLK_SYS, RST, CMD_VALID, RD_VALID, OC_REPORT_PER_PORT, OC_REPORT_NONE,
   input wire logic [7:0] CMD_CODE, POWER_GOOD_DELAY,
   input wire logic [31:0] WR_DATA, RD_DATA
);
   logic [31:0] d1, d2;
   always_ff @(posedge CLK_SYS) {d2, d1} <= {d1, WR_DATA};
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   sequence wr; CMD_VALID && CMD_CODE == 8'h92; endsequence
   AST_RD: assert property (CMD_VALID && CMD_CODE == 8'h12 |=> RD_VALID) else $error("rd");
   AST_DT: assert property (RD_VALID |-> !RD_DATA[10]) else $error("dt");
   AST_RSV: assert property (RD_VALID |-> {RD_DATA[23:13], RD_DATA[7:2]} == 17'h0)
      else $error("rsv");
   AST_NDP: assert property (RD_VALID |-> RD_DATA[1:0] <= 2'h2) else $error("ndp");
   AST_PGD: assert property (wr |-> ##2 POWER_GOOD_DELAY == d2[31:24]) else $error("pgd");
   AST_NOC: assert property (wr |-> ##2 OC_REPORT_NONE == d2[12]) else $error("noc");
   AST_OCM: assert property (wr |-> ##2 OC_REPORT_PER_PORT == (!d2[12] && d2[11]))
      else $error("ocm");
   AST_RST: assert property ($fell(RST) |=> OC_REPORT_PER_PORT) else $error("rst");
endmodule
`default_nettype wire

// >>> test/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic CLK_SYS, // Clock.
   input wire logic [31:0] RD_DATA, // Read value.
   output logic CMD_VALID = 1'b0, // Strobe.
   output logic [7:0] CMD_CODE = 8'h0, // Code.
   output logic [31:0] WR_DATA = 32'h0 // Data.
);
   task automatic cmd(logic [7:0] c, logic [31:0] d, output logic [31:0] q);
      @(posedge CLK_SYS) #1 {CMD_VALID, CMD_CODE, WR_DATA} = {1'b1, c, d};
      @(posedge CLK_SYS) #1 {CMD_VALID, WR_DATA} = {1'b0, ~d};
      q = RD_DATA;
   endtask
endmodule
`default_nettype wire

// >>> test/root_hub_descriptor_a_bench.sv
`timescale 1ns/1ps
`default_nettype none
module root_hub_descriptor_a_bench;
   logic clk = 0, rst = 1, cv, rv, gon = 0, goff = 0;
   logic [7:0] cc;
   logic [31:0] wd, rdd, q, w, lfsr = 32'hd531;
   logic [2:0] pw, msk = 0, ps = 0, pc = 0, epw = 0;
   logic [1:0] strap = 2'h3;
   logic nps_m = 1'b0, psm_m = 1'b1;
   int err_total = 0, n_checks = 0;
   always #4 clk = ~clk;
   root_hub_descriptor_a u_dut (.CLK_SYS(clk), .RST(rst), .CMD_VALID(cv), .CMD_CODE(cc),
      .WR_DATA(wd), .PORT_COUNT_STRAP(strap), .GLOBAL_POWER_ON(gon), .GLOBAL_POWER_OFF(goff),
      .PORT_POWER_MASK(msk), .PORT_POWER_SET(ps), .PORT_POWER_CLR(pc), .RD_DATA(rdd),
      .RD_VALID(rv), .POWER_GOOD_DELAY(), .OC_REPORT_PER_PORT(), .OC_REPORT_NONE(),
      .PORT_POWER(pw));
   host_model host (.CLK_SYS(clk), .RD_DATA(rdd), .CMD_VALID(cv), .CMD_CODE(cc), .WR_DATA(wd));
   function automatic logic [31:0] nxt(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [31:0] exp_rd(logic [31:0] x, logic [1:0] n);
      return {x[31:24], 11'h0, x[12:11], 1'b0, x[9:8], 6'h0, (n > 2'h2) ? 2'h2 : n};
   endfunction
   always @(posedge clk) lfsr <= nxt(lfsr);
   // Reference port power: forced on, per-port commands when masked in per-port mode, else global.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         epw <= 3'h0;
      end else begin
         for (int k = 1; k < 3; k++) begin
            epw[k] <= nps_m ? 1'b1 : (psm_m && msk[k]) ? (ps[k] | (epw[k] & ~pc[k])) :
               (gon | (epw[k] & ~goff));
         end
      end
   end
   always @(posedge clk) #1 {gon, goff, msk, ps, pc} = lfsr[10:0];
   task chk(string nm, logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) $display("BAD %s exp %h seen %h", nm, exp, seen);
      err_total += (seen !== exp);
   endtask
   task end_sim;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      #1 rst = 0;
      host.cmd(8'h12, 32'h0, q);
      chk("reset", q, 32'h0100_0902);
      for (int i = 0; i < 40; i++) begin
         w = i ? lfsr : 32'h800;
         strap = lfsr[13:12];
         host.cmd(8'h92, w, q);
         {nps_m, psm_m} = w[9:8];
         host.cmd({w[7], 7'h13}, ~w, q);
         host.cmd(8'h12, 32'h0, q);
         chk("desc", q, exp_rd(w, strap));
         chk("valid", {31'h0, rv}, 32'h1);
         if (w[9]) chk("power", {29'h0, pw}, 32'h6);
         chk("ports", {29'h0, pw}, {29'h0, epw[2:1], 1'b0});
      end
      rst = 1;
      {nps_m, psm_m} = 2'b01;
      @(posedge clk);
      #1 rst = 0;
      host.cmd(8'h12, 32'h0, q);
      chk("reset2", q, exp_rd(32'h0100_0900, strap));
      end_sim();
   end
endmodule
bind root_hub_descriptor_a rh_desc_assertions chk_i (.CLK_SYS, .RST, .CMD_VALID, .RD_VALID,
   .OC_REPORT_PER_PORT, .OC_REPORT_NONE, .CMD_CODE, .POWER_GOOD_DELAY, .WR_DATA, .RD_DATA);
`default_nettype wire
